// File: src/vbsc_dev.sv
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/10ps
module vbsc_dev #(
  parameter int NUM_CH = vbsc_pkg::NUM_CH
) (
  input  wire logic                   clk_in,
  input  wire logic                   rstn_in,
  vbsc_if.dev                         link,
  input  wire logic                   power_up_state_strap_in,
  input  wire logic                   slave_addr_select_hi_in,
  input  wire logic                   slave_addr_select_lo_in,
  output logic [NUM_CH-1:0]           monitor_en_out,
  output logic [NUM_CH-1:0]           buffer_en_out,
  output logic [NUM_CH-1:0][7:0]      ch_reg_out,
  output logic [7:0]                  global_sync_path_control_out,
  output logic                        vsync_sel_b_out,
  output logic                        hsync_sel_b_out,
  output logic                        sync_en_out
);
  import vbsc_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_SUB, ST_DATA, ST_READ, ST_SKIP
  } vbsc_st_t;

  logic [4:0]            sync1;
  logic [4:0]            sync2;
  logic                  scl_q;
  logic                  sda_q;
  logic                  scl_rise;
  logic                  scl_fall;
  logic                  start_seen;
  logic                  stop_seen;
  logic [1:0]            settle_cnt;
  logic                  settled;
  vbsc_st_t              state;
  logic [3:0]            bit_cnt;
  logic                  ack_slot;
  logic                  sda_oe;
  logic [7:0]            shreg;
  logic [7:0]            tx;
  logic [7:0]            sub_addr;
  logic [7:0]            rd_byte;
  logic [NUM_CH-1:0][7:0] ch_reg;
  logic [7:0]            global_sync_path_control;
  logic                  byte_end;
  logic                  addr_hit;
  logic                  sub_ok;
  logic                  wr_en;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // every pin crosses two flops; only sync2 feeds logic
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync1 <= 5'h18; // strap rests low so a low strap never flashes paths on
      sync2 <= 5'h18;
    end else begin
      sync1 <= {link.scl, link.sda, power_up_state_strap_in,
                slave_addr_select_hi_in, slave_addr_select_lo_in};
      sync2 <= sync1;
    end
  end

  // previous line levels for edge and condition detection
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= sync2[4];
      sda_q <= sync2[3];
    end
  end

  assign scl_rise   = sync2[4] & ~scl_q;
  assign scl_fall   = ~sync2[4] & scl_q;
  assign start_seen = sync2[4] & scl_q & sda_q & ~sync2[3];
  assign stop_seen  = sync2[4] & scl_q & ~sda_q & sync2[3];

  // ----------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------
  // strap is a pin, so it is reloaded until the synchroniser has settled
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      settle_cnt <= 2'h0;
    end else if (settle_cnt != STRAP_SETTLE) begin
      settle_cnt <= settle_cnt + 2'h1;
    end
  end
  assign settled = (settle_cnt == STRAP_SETTLE);

  // ----------------------------------------------------------------
  // byte decode
  // ----------------------------------------------------------------
  assign byte_end = scl_fall & ~ack_slot & (bit_cnt == 4'h8);
  assign addr_hit = (shreg[7:1] == {DEV_ADDR_FIXED, sync2[1], sync2[0]});
  assign sub_ok   = (shreg[7:SUB_ZERO_LSB] == 5'h00);
  // one data byte per transaction, then the slave goes deaf
  assign wr_en    = byte_end & (state == ST_DATA) & settled;

  // read source follows the latched subaddress
  always_comb begin
    rd_byte = 8'h00;
    if (sub_addr == SUB_GLOBAL) begin
      rd_byte = global_sync_path_control;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (sub_addr == SUB_CH1 + 8'(i)) begin
        rd_byte = ch_reg[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // serial protocol engine
  // ----------------------------------------------------------------
  // sda only moves after a falling scl, never while scl is high
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state    <= ST_IDLE;
      bit_cnt  <= 4'h0;
      ack_slot <= 1'b0;
      sda_oe   <= 1'b0;
      shreg    <= 8'h00;
      tx       <= 8'h00;
    end else if (start_seen) begin
      state    <= ST_ADDR;
      bit_cnt  <= 4'h0;
      ack_slot <= 1'b0;
      sda_oe   <= 1'b0;
    end else if (stop_seen) begin
      state    <= ST_IDLE;
      ack_slot <= 1'b0;
      sda_oe   <= 1'b0;
    end else if (scl_rise && !ack_slot && state != ST_IDLE && state != ST_SKIP) begin
      shreg   <= {shreg[6:0], sync2[3]};
      bit_cnt <= bit_cnt + 4'h1;
    end else if (scl_fall) begin
      if (ack_slot) begin
        ack_slot <= 1'b0;
        bit_cnt  <= 4'h0;
        if (state == ST_READ) begin
          tx     <= rd_byte;
          sda_oe <= ~rd_byte[7];
        end else begin
          sda_oe <= 1'b0;
        end
      end else if (byte_end) begin
        case (state)
          ST_ADDR: begin
            if (addr_hit) begin
              ack_slot <= 1'b1;
              sda_oe   <= 1'b1;
              state    <= shreg[0] ? ST_READ : ST_SUB;
            end else begin
              state <= ST_SKIP;
            end
          end
          ST_SUB: begin
            ack_slot <= sub_ok;
            sda_oe   <= sub_ok;
            state    <= sub_ok ? ST_DATA : ST_SKIP;
          end
          ST_DATA: begin
            ack_slot <= 1'b1;
            sda_oe   <= 1'b1;
            state    <= ST_SKIP;
          end
          ST_READ: begin
            // master's acknowledge slot; any further byte is not served
            sda_oe <= 1'b0;
            state  <= ST_SKIP;
          end
          default: begin
            state <= ST_SKIP;
          end
        endcase
      end else if (state == ST_READ && bit_cnt != 4'h0) begin
        tx     <= {tx[6:0], 1'b0};
        sda_oe <= ~tx[6];
      end
    end
  end

  // ----------------------------------------------------------------
  // subaddress latch
  // ----------------------------------------------------------------
  // never cleared by stop, so a later read phase finds it
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sub_addr <= 8'h00;
    end else if (byte_end && state == ST_SUB && sub_ok) begin
      sub_addr <= shreg;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // strap image holds until the first completed write
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      global_sync_path_control <= GBL_RST_LO;
    end else if (!settled) begin
      global_sync_path_control <= sync2[2] ? GBL_RST_HI : GBL_RST_LO;
    end else if (wr_en && sub_addr == SUB_GLOBAL) begin
      global_sync_path_control <= shreg;
    end
  end

  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          ch_reg[c] <= CH_RST_LO;
        end else if (!settled) begin
          ch_reg[c] <= sync2[2] ? CH_RST_HI : CH_RST_LO;
        end else if (wr_en && sub_addr == SUB_CH1 + 8'(c)) begin
          ch_reg[c] <= shreg;
        end
      end

      // a channel mode of all zero switches off both of its paths
      always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          monitor_en_out[c] <= 1'b0;
          buffer_en_out[c]  <= 1'b0;
        end else begin
          monitor_en_out[c] <= global_sync_path_control[GBL_MON_EN]
                               & (ch_reg[c][CH_MODE_MSB:0] != CH_MODE_OFF);
          buffer_en_out[c]  <= global_sync_path_control[GBL_BUF_EN]
                               & (ch_reg[c][CH_MODE_MSB:0] != CH_MODE_OFF);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // sync path outputs
  // ----------------------------------------------------------------
  // reserved codes 10/11 fall back on the low bit; bit 7 is never decoded
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      vsync_sel_b_out <= 1'b0;
      hsync_sel_b_out <= 1'b0;
      sync_en_out     <= 1'b0;
      ch_reg_out      <= '0;
      global_sync_path_control_out <= 8'h00;
    end else begin
      vsync_sel_b_out <= global_sync_path_control[GBL_VSEL_LSB];
      hsync_sel_b_out <= global_sync_path_control[GBL_HSEL_LSB];
      sync_en_out     <= global_sync_path_control[GBL_SYNC_EN];
      ch_reg_out      <= ch_reg;
      global_sync_path_control_out <= global_sync_path_control;
    end
  end

  assign link.s_sda_o  = 1'b0;
  assign link.s_sda_oe = sda_oe;
endmodule

// File: src/vbsc_pkg.sv
package vbsc_pkg;
  // ----------------------------------------------------------------
  // clocking and serial timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_KHZ = 40000;
  localparam int SCL_FREQ_KHZ = 400;
  // host holds each quarter of a serial bit for this many cycles
  localparam int SCL_QTR_CYC = (CLK_FREQ_KHZ + 4 * SCL_FREQ_KHZ - 1) / (4 * SCL_FREQ_KHZ);
  // cycles the strap is reloaded after reset release
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ----------------------------------------------------------------
  // slave address and subaddress map
  // ----------------------------------------------------------------
  localparam int NUM_CH = 3;
  localparam logic [4:0] DEV_ADDR_FIXED = 5'h0b;
  localparam logic [7:0] SUB_CH1 = 8'h01;
  localparam logic [7:0] SUB_GLOBAL = 8'h04;
  localparam int SUB_ZERO_LSB = 3;

  // ----------------------------------------------------------------
  // global_sync_path_control and channel mode fields
  // ----------------------------------------------------------------
  localparam int GBL_MON_EN = 6;
  localparam int GBL_BUF_EN = 5;
  localparam int GBL_VSEL_LSB = 3;
  localparam int GBL_HSEL_LSB = 1;
  localparam int GBL_SYNC_EN = 0;
  localparam int CH_MODE_MSB = 2;
  localparam logic [2:0] CH_MODE_OFF = 3'h0;

  // ----------------------------------------------------------------
  // power-up contents by strap level
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_RST_LO = 8'h00;
  localparam logic [7:0] CH_RST_HI = 8'h04;
  localparam logic [7:0] GBL_RST_LO = 8'h00;
  localparam logic [7:0] GBL_RST_HI = 8'h40;

  // ----------------------------------------------------------------
  // host command registers
  // ----------------------------------------------------------------
  localparam logic [2:0] HREG_CMD = 3'h0;
  localparam logic [2:0] HREG_SUB = 3'h1;
  localparam logic [2:0] HREG_WDATA = 3'h2;
  localparam logic [2:0] HREG_ADDR_LO = 3'h3;
  localparam logic [2:0] HREG_STATUS = 3'h4;
  localparam logic [2:0] HREG_RDATA = 3'h5;
  localparam int CMD_WRITE = 0;
  localparam int CMD_READ = 1;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
endpackage

// File: src/vbsc_if.sv
`timescale 1ns/10ps
// open-drain two-wire link; a low wins whenever any end enables its driver
interface vbsc_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // ----------------------------------------------------------------
  // wired level with pull-up
  // ----------------------------------------------------------------
  assign scl = m_scl_oe ? m_scl_o : 1'b1;
  assign sda = (m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o) ? 1'b0 : 1'b1;

  modport dev (input scl, input sda, output s_sda_o, output s_sda_oe);
  modport host (input scl, input sda, output m_scl_o, output m_scl_oe,
                output m_sda_o, output m_sda_oe);
endinterface

// File: src/vbsc_host.sv
`timescale 1ns/10ps
module vbsc_host #(
  parameter int QTR_CYC = vbsc_pkg::SCL_QTR_CYC
) (
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  vbsc_if.host            link,
  input  wire logic [2:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic [7:0]      rdata_out
);
  import vbsc_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_START, H_TX, H_RX, H_STOP} vbsc_hst_t;

  logic       sda_s1;
  logic       sda_s2;
  logic [7:0] sub_reg;
  logic [7:0] wdata_reg;
  logic [1:0] addr_lo;
  logic [7:0] rx_byte;
  logic       nack;
  logic       op_rd;
  vbsc_hst_t  state;
  logic [3:0] seg;
  logic [3:0] nseg;
  logic [3:0] bit_idx;
  logic [1:0] qtr;
  logic [15:0] div_cnt;
  logic       tick;
  logic       scl_oe;
  logic       sda_oe;
  logic [7:0] tx;

  // write: S adr sub data P; read: S adr sub P S adr+r rx P
  function automatic vbsc_hst_t seg_kind(input logic [3:0] s, input logic rd);
    seg_kind = H_IDLE;
    case (s)
      4'h0: seg_kind = H_START;
      4'h1, 4'h2: seg_kind = H_TX;
      4'h3: seg_kind = rd ? H_STOP : H_TX;
      4'h4: seg_kind = rd ? H_START : H_STOP;
      4'h5: seg_kind = rd ? H_TX : H_IDLE;
      4'h6: seg_kind = rd ? H_RX : H_IDLE;
      4'h7: seg_kind = rd ? H_STOP : H_IDLE;
      default: seg_kind = H_IDLE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // command registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sub_reg   <= 8'h00;
      wdata_reg <= 8'h00;
      addr_lo   <= 2'h0;
    end else if (wr_in) begin
      if (addr_in == HREG_SUB) sub_reg <= wdata_in;
      if (addr_in == HREG_WDATA) wdata_reg <= wdata_in;
      if (addr_in == HREG_ADDR_LO) addr_lo <= wdata_in[1:0];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        HREG_SUB:     rdata_out <= sub_reg;
        HREG_WDATA:   rdata_out <= wdata_reg;
        HREG_ADDR_LO: rdata_out <= {6'h00, addr_lo};
        HREG_STATUS:  rdata_out <= {6'h00, nack, state != H_IDLE};
        HREG_RDATA:   rdata_out <= rx_byte;
        default:      rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // line sampling and quarter-bit timer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      sda_s1 <= link.sda;
      sda_s2 <= sda_s1;
    end
  end

  assign tick = (div_cnt == 16'(QTR_CYC - 1));
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_cnt <= 16'h0000;
    end else if (state == H_IDLE || tick) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  // a refused address byte cuts straight to the closing stop
  always_comb begin
    nseg = seg + 4'h1;
    if (state == H_TX && bit_idx == 4'h8 && sda_s2) nseg = op_rd ? 4'h7 : 4'h4;
  end

  always_comb begin
    tx = sub_reg;
    if (seg == 4'h1) tx = {DEV_ADDR_FIXED, addr_lo, 1'b0};
    if (seg == 4'h3) tx = wdata_reg;
    if (seg == 4'h5) tx = {DEV_ADDR_FIXED, addr_lo, 1'b1};
  end

  // ----------------------------------------------------------------
  // bit sequencer
  // ----------------------------------------------------------------
  // sda changes only with scl held low, except for start and stop
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state   <= H_IDLE;
      seg     <= 4'h0;
      bit_idx <= 4'h0;
      qtr     <= 2'h0;
      op_rd   <= 1'b0;
      nack    <= 1'b0;
      rx_byte <= 8'h00;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
    end else if (state == H_IDLE) begin
      if (wr_in && addr_in == HREG_CMD && (wdata_in[CMD_WRITE] || wdata_in[CMD_READ])) begin
        op_rd   <= wdata_in[CMD_READ] & ~wdata_in[CMD_WRITE];
        state   <= H_START;
        seg     <= 4'h0;
        bit_idx <= 4'h0;
        qtr     <= 2'h0;
        nack    <= 1'b0;
      end
    end else if (tick) begin
      qtr <= qtr + 2'h1;
      case (state)
        H_START: begin
          if (qtr == 2'h0) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
          end
          if (qtr == 2'h2) sda_oe <= 1'b1;
          if (qtr == 2'h3) scl_oe <= 1'b1;
        end
        H_STOP: begin
          if (qtr == 2'h0) scl_oe <= 1'b1;
          if (qtr == 2'h1) sda_oe <= 1'b1;
          if (qtr == 2'h2) scl_oe <= 1'b0;
          if (qtr == 2'h3) sda_oe <= 1'b0;
        end
        H_TX, H_RX: begin
          if (qtr == 2'h0) scl_oe <= 1'b1;
          if (qtr == 2'h1) begin
            sda_oe <= (state == H_TX && bit_idx != 4'h8) ? ~tx[3'(4'h7 - bit_idx)] : 1'b0;
          end
          if (qtr == 2'h2) scl_oe <= 1'b0;
          if (qtr == 2'h3 && state == H_TX && bit_idx == 4'h8) nack <= sda_s2;
          if (qtr == 2'h3 && state == H_RX && bit_idx != 4'h8) begin
            rx_byte <= {rx_byte[6:0], sda_s2};
          end
        end
        default: begin
          scl_oe <= 1'b0;
        end
      endcase
      if (qtr == 2'h3) begin
        if ((state == H_TX || state == H_RX) && bit_idx != 4'h8) begin
          bit_idx <= bit_idx + 4'h1;
        end else begin
          bit_idx <= 4'h0;
          seg     <= nseg;
          state   <= seg_kind(nseg, op_rd);
        end
      end
    end
  end

  assign link.m_scl_o  = 1'b0;
  assign link.m_scl_oe = scl_oe;
  assign link.m_sda_o  = 1'b0;
  assign link.m_sda_oe = sda_oe;
endmodule

// File: verif/vbsc_properties.sv
`timescale 1ns/10ps
module vbsc_properties #(
  parameter int NUM_CH = vbsc_pkg::NUM_CH
) (
  input wire logic                    clk_in,
  input wire logic                    rstn_in,
  input wire logic                    scl,
  input wire logic                    s_sda_oe,
  input wire logic                    power_up_state_strap_in,
  input wire logic [NUM_CH-1:0]       monitor_en_out,
  input wire logic [NUM_CH-1:0]       buffer_en_out,
  input wire logic [NUM_CH-1:0][7:0]  ch_reg_out,
  input wire logic [7:0]              global_sync_path_control_out,
  input wire logic                    vsync_sel_b_out,
  input wire logic                    hsync_sel_b_out,
  input wire logic                    sync_en_out
);
  import vbsc_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  logic [NUM_CH-1:0] ch_on;
  logic [7:0]        g;
  assign g = global_sync_path_control_out;
  // a channel is live unless its mode field is off; mute still counts as live
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      ch_on[i] = ch_reg_out[i][CH_MODE_MSB:0] != CH_MODE_OFF;
    end
  end
  // outputs lag the registers by a cycle, so only judge them once settled
  sequence s_settled;
    ($stable(g) && $stable(ch_reg_out)) [*2];
  endsequence
  property p_sync_en; s_settled |-> sync_en_out == g[GBL_SYNC_EN]; endproperty
  a_sync_en: assert property (p_sync_en) else $error("sync enable wrong");
  property p_hsel; s_settled |-> hsync_sel_b_out == g[GBL_HSEL_LSB]; endproperty
  a_hsel: assert property (p_hsel) else $error("hsync select wrong");
  property p_vsel; s_settled |-> vsync_sel_b_out == g[GBL_VSEL_LSB]; endproperty
  a_vsel: assert property (p_vsel) else $error("vsync select wrong");
  property p_mon; s_settled |-> monitor_en_out == ({NUM_CH{g[GBL_MON_EN]}} & ch_on); endproperty
  a_mon: assert property (p_mon) else $error("monitor enable wrong");
  property p_buf; s_settled |-> buffer_en_out == ({NUM_CH{g[GBL_BUF_EN]}} & ch_on); endproperty
  a_buf: assert property (p_buf) else $error("buffer enable wrong");
  property p_rsvd;
    // outputs move in the same cycle as the register copy, so judge that cycle
    $changed(g[7]) && $stable(g[6:0]) && $stable(ch_reg_out) |->
      $stable({monitor_en_out, buffer_en_out, sync_en_out, hsync_sel_b_out, vsync_sel_b_out});
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("top global bit had an effect");
  // slave may only move its line while the clock is low, else it fakes start or stop
  property p_sda_low; $changed(s_sda_oe) |-> !scl; endproperty
  a_sda_low: assert property (p_sda_low) else $error("data moved with clock high");
  property p_ack_hold; $rose(s_sda_oe) |-> s_sda_oe [*8]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("slave low bit too short");
  property p_strap;
    $rose(rstn_in) |-> ##6 g == (power_up_state_strap_in ? GBL_RST_HI : GBL_RST_LO) &&
      ch_reg_out[0] == (power_up_state_strap_in ? CH_RST_HI : CH_RST_LO);
  endproperty
  a_strap: assert property (p_strap) else $error("power-up contents wrong");
  c_ack: cover property ($rose(s_sda_oe));
  c_write: cover property ($changed(g));
  c_live: cover property (s_settled ##0 g[GBL_MON_EN] && (|ch_on));
endmodule

// File: verif/video_buffer_i2c_sync_control_tb.sv
`timescale 1ns/10ps
module video_buffer_i2c_sync_control_tb;
  import vbsc_pkg::*;
  logic            clk_in = 1'b0;
  logic            rstn_in = 1'b0;
  logic            strap = 1'b0;
  logic [1:0]      asel = 2'h0;
  logic [2:0]      addr_in = 3'h0;
  logic [7:0]      wdata_in = 8'h00;
  logic            wr_in = 1'b0;
  logic            rd_in = 1'b0;
  logic [7:0]      rdata_out;
  logic [2:0]      mon;
  logic [2:0]      bfe;
  logic [2:0][7:0] ch;
  logic [2:0][7:0] ech;
  logic [7:0]      gbl;
  logic [7:0]      eg;
  logic [7:0]      st;
  logic [7:0]      rv;
  logic [7:0]      g;
  logic            vs;
  logic            hs;
  logic            se;
  int              errors = 0;
  int              n_checks = 0;
  int              cyc = 0;
  always #12.5 clk_in = ~clk_in;
  vbsc_if u_vbsc_if ();
  vbsc_dev u_vbsc_dev (.clk_in(clk_in), .rstn_in(rstn_in), .link(u_vbsc_if),
    .power_up_state_strap_in(strap), .slave_addr_select_hi_in(asel[1]),
    .slave_addr_select_lo_in(asel[0]), .monitor_en_out(mon), .buffer_en_out(bfe),
    .ch_reg_out(ch), .global_sync_path_control_out(gbl), .vsync_sel_b_out(vs),
    .hsync_sel_b_out(hs), .sync_en_out(se));
  // short quarters keep each serial write under a thousand cycles and each read at 1280
  vbsc_host #(.QTR_CYC(8)) u_vbsc_host (.clk_in(clk_in), .rstn_in(rstn_in),
    .link(u_vbsc_if), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in), .rdata_out(rdata_out));
  vbsc_properties u_vbsc_properties (.clk_in(clk_in), .rstn_in(rstn_in),
    .scl(u_vbsc_if.scl), .s_sda_oe(u_vbsc_if.s_sda_oe), .power_up_state_strap_in(strap),
    .monitor_en_out(mon), .buffer_en_out(bfe), .ch_reg_out(ch),
    .global_sync_path_control_out(gbl), .vsync_sel_b_out(vs), .hsync_sel_b_out(hs),
    .sync_en_out(se));
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // cycle ceiling well above the roughly thirty thousand cycles of traffic
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors = errors + 1;
      end_sim();
    end
  end
  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  // one full link operation, then poll status until the host is idle
  task automatic op(input logic [1:0] c, input logic [7:0] sb, input logic [7:0] d,
                    input logic [1:0] alo);
    int n;
    wr(HREG_SUB, sb);
    wr(HREG_WDATA, d);
    wr(HREG_ADDR_LO, {6'h00, alo});
    wr(HREG_CMD, {6'h00, c});
    n = 0;
    st = 8'h01;
    while (st[STAT_BUSY] !== 1'b0 && n < 3000) begin
      rd(HREG_STATUS, st);
      n++;
    end
    cmp("busy", 8'h00, {7'h00, st[STAT_BUSY]});
  endtask
  task automatic chk_all();
    logic [2:0] on;
    for (int i = 0; i < 3; i++) on[i] = ech[i][2:0] != CH_MODE_OFF;
    @(posedge clk_in);
    #1 cmp("global", eg, gbl);
    for (int i = 0; i < 3; i++) cmp("channel", ech[i], ch[i]);
    cmp("monitor", {5'h00, {3{eg[GBL_MON_EN]}} & on}, {5'h00, mon});
    cmp("buffer", {5'h00, {3{eg[GBL_BUF_EN]}} & on}, {5'h00, bfe});
    cmp("sync", {5'h00, eg[3], eg[1], eg[0]}, {5'h00, vs, hs, se});
  endtask
  task automatic rdback(input logic [7:0] sb, input logic [7:0] e);
    op(2'h2, sb, 8'h00, asel);
    rd(HREG_RDATA, rv);
    cmp("rdata", e, rv);
    cmp("nack", 8'h00, {7'h00, st[STAT_NACK]});
    rd(HREG_SUB, rv);
    cmp("sub", sb, rv);
  endtask
  initial begin
    void'($urandom(68030));
    asel = 2'($urandom);
    // cold start with the strap low, then a second reset with it high
    for (int r = 0; r < 2; r++) begin
      repeat (12) @(posedge clk_in);
      rstn_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      eg = r ? GBL_RST_HI : GBL_RST_LO;
      ech = r ? {3{CH_RST_HI}} : {3{CH_RST_LO}};
      chk_all();
      // only the cold start is followed by a second reset; the run needs it released
      if (r == 0) begin
        @(posedge clk_in);
        rstn_in <= 1'b0;
        strap <= 1'b1;
      end
    end
    // host target bits read back as written
    wr(HREG_ADDR_LO, 8'h03);
    rd(HREG_ADDR_LO, rv);
    cmp("addr_lo", 8'h03, rv);
    rdback(SUB_GLOBAL, eg);
    // every sync select code, a top-bit-only change, then random bytes
    for (int i = 0; i < 9; i++) begin
      g = 8'($urandom);
      if (i < 4) g[4:1] = {2'(i), ~2'(i)};
      if (i == 4) g = eg ^ 8'h80;
      op(2'h1, SUB_GLOBAL, g, asel);
      eg = g;
      chk_all();
      rdback(SUB_GLOBAL, g);
    end
    op(2'h1, SUB_GLOBAL, 8'h61, asel);
    eg = 8'h61;
    // channel writes, the first pass with the mode field off
    for (int i = 0; i < 6; i++) begin
      g = 8'($urandom);
      if (i < 3) g[2:0] = CH_MODE_OFF;
      op(2'h1, SUB_CH1 + 8'(i % 3), g, asel);
      ech[i % 3] = g;
      chk_all();
    end
    rdback(SUB_CH1 + 8'h02, ech[2]);
    // foreign address and a subaddress with upper bits set must be refused
    op(2'h1, SUB_GLOBAL, 8'h00, asel ^ 2'h1);
    cmp("nack", 8'h01, {7'h00, st[STAT_NACK]});
    op(2'h1, 8'h24, 8'h00, asel);
    cmp("nack", 8'h01, {7'h00, st[STAT_NACK]});
    chk_all();
    end_sim();
  end
endmodule
